// [core/gts_pkg.sv]
// constants and types for the gear-tooth switchpoint logic
// assumes one 50 MHz clock and a digitised differential sample stream
//
// What this block does
// - forward rotation: output rises on tooth leading edge, high while tooth near.
// - reverse rotation inverts polarity: high on falling edge, valley nearest.
// - below undervoltage threshold, reset and hold power-on output state.
// - power-on calibration measures peak-to-peak amplitude and sets gain.
// - gain control stays on in running mode, re-adjusting rarely and cautiously.
// - offset adjust runs in both modes, tracking drift: per sample in calibration, per output transition in running mode.
// - offset and gain together centre the signal in range during calibration.
// - switching thresholds are recomputed continuously from the received signal.
// - every output transition resets both peak trackers.
// - peak tracking is clipped at a bounding limit.
// - in running mode, small amplitude freezes the output until amplitude returns.
// - one tracker follows high peaks, the other follows low peaks.
// - trackers follow to peak or bound; captured peaks set next switchpoint.
`default_nettype none

package gts_pkg;

  // ==========================================================
  // data widths
  localparam int DW = 12;
  typedef logic signed [DW-1:0] gts_word_t;
  typedef logic signed [15:0]   gts_wide_t;

  // ==========================================================
  // signal levels
  localparam gts_wide_t WORD_MAX    = 16'sh07ff;
  localparam gts_wide_t WORD_MIN    = -16'sh0800;
  localparam gts_wide_t BOUND_LIMIT = 16'sh0700;
  localparam gts_wide_t TARGET_PP   = 16'sh0600;
  localparam gts_word_t TARGET_HALF = 12'sh300;
  localparam gts_wide_t GAIN_HI_PP  = 16'sh0c00;
  localparam gts_wide_t GAIN_LO_PP  = 16'sh0300;
  localparam gts_wide_t LOCK_MIN_PP = 16'sh0100;
  localparam gts_wide_t HYST        = 16'sh0020;
  localparam gts_wide_t OFFS_DEAD   = 16'sh0008;
  localparam int        FRAC_SHIFT  = 1;

  // ==========================================================
  // counts and reset values
  localparam logic [15:0] CAL_SAMPLES  = 16'h0400;
  localparam logic [3:0]  GAIN_PERSIST = 4'h8;
  localparam logic [2:0]  MAX_SHIFT    = 3'h7;
  localparam logic        POS_LEVEL    = 1'b0;

  // ==========================================================
  // state
  typedef enum logic {MODE_CAL, MODE_RUN} gts_mode_t;

  typedef struct packed {
    gts_mode_t   mode;
    logic [15:0] calCount;
    gts_word_t   calMax;
    gts_word_t   calMin;
    gts_word_t   offset;
    logic [2:0]  gainShift;
    logic [3:0]  gainCount;
    gts_word_t   diffSignal;
    logic        procValid;
    gts_word_t   hiTrack;
    gts_word_t   loTrack;
    gts_word_t   capHi;
    gts_word_t   capLo;
    logic        lockout;
    logic        out;
    logic        pinLow;
  } gts_state_t;

endpackage

`default_nettype wire

// [core/gts_switchpoint.sv]
// adaptive switchpoint logic of a differential gear-tooth sensor
// assumes samples synchronous to clock, supplyOk from the supply comparator
`default_nettype none

module gts_switchpoint (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // differential sample stream
  input  wire gts_pkg::gts_word_t sampleData,
  input  wire logic              sampleValid,
  // high while supply is above the undervoltage threshold
  input  wire logic              supplyOk,
  // output
  output var  logic              outState,
  output var  logic              outPinEnable,
  output var  logic              calibrating,
  output var  logic              lockedOut
);

  // ==========================================================
  // helpers
  function automatic gts_pkg::gts_word_t satWord(gts_pkg::gts_wide_t x);
    if (x > gts_pkg::WORD_MAX)
      satWord = gts_pkg::gts_word_t'(gts_pkg::WORD_MAX);
    else if (x < gts_pkg::WORD_MIN)
      satWord = gts_pkg::gts_word_t'(gts_pkg::WORD_MIN);
    else
      satWord = gts_pkg::gts_word_t'(x);
  endfunction

  function automatic gts_pkg::gts_word_t clipBound(gts_pkg::gts_wide_t x);
    if (x > gts_pkg::BOUND_LIMIT)
      clipBound = gts_pkg::gts_word_t'(gts_pkg::BOUND_LIMIT);
    else if (x < -gts_pkg::BOUND_LIMIT)
      clipBound = gts_pkg::gts_word_t'(-gts_pkg::BOUND_LIMIT);
    else
      clipBound = gts_pkg::gts_word_t'(x);
  endfunction

  function automatic gts_pkg::gts_wide_t widen(gts_pkg::gts_word_t x);
    widen = gts_pkg::gts_wide_t'(x);
  endfunction

  // shift in 32 bits so a large gain saturates instead of wrapping
  function automatic gts_pkg::gts_word_t satShift(gts_pkg::gts_wide_t v,
                                                  logic [2:0]         sh);
    int t;
    t = int'(v) <<< sh;
    if (t > int'(gts_pkg::WORD_MAX))
      satShift = gts_pkg::gts_word_t'(gts_pkg::WORD_MAX);
    else if (t < int'(gts_pkg::WORD_MIN))
      satShift = gts_pkg::gts_word_t'(gts_pkg::WORD_MIN);
    else
      satShift = gts_pkg::gts_word_t'(t);
  endfunction

  // largest shift that keeps the amplitude within target
  function automatic logic [2:0] gainFor(gts_pkg::gts_wide_t pp);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 1; i <= int'(gts_pkg::MAX_SHIFT); i++) begin
      // 32-bit compare, a 16-bit shift would wrap negative
      if ((int'(pp) <<< i) <= int'(gts_pkg::TARGET_PP))
        s = 3'(i);
    end
    gainFor = s;
  endfunction

  function automatic gts_pkg::gts_word_t nudge(gts_pkg::gts_word_t v,
                                              gts_pkg::gts_wide_t err);
    if (err > gts_pkg::OFFS_DEAD)
      nudge = satWord(widen(v) + 16'sh0001);
    else if (err < -gts_pkg::OFFS_DEAD)
      nudge = satWord(widen(v) - 16'sh0001);
    else
      nudge = v;
  endfunction

  function automatic gts_pkg::gts_state_t resetState();
    gts_pkg::gts_state_t r;
    r            = '0;
    r.mode       = gts_pkg::MODE_CAL;
    r.out        = gts_pkg::POS_LEVEL;
    r.pinLow     = ~gts_pkg::POS_LEVEL;
    resetState   = r;
  endfunction

  // ==========================================================
  // state
  gts_pkg::gts_state_t s;
  gts_pkg::gts_state_t next_s;

  gts_pkg::gts_wide_t corr;
  gts_pkg::gts_wide_t calMid;
  gts_pkg::gts_wide_t capPP;
  gts_pkg::gts_wide_t trkPP;
  gts_pkg::gts_wide_t newPP;
  gts_pkg::gts_wide_t thrMid;
  gts_pkg::gts_wide_t thrRise;
  gts_pkg::gts_wide_t thrFall;
  gts_pkg::gts_wide_t x;
  gts_pkg::gts_word_t smpMax;
  gts_pkg::gts_word_t smpMin;
  logic               switched;

  always_comb begin
    next_s   = s;
    corr     = widen(sampleData) - widen(s.offset);
    x        = widen(s.diffSignal);
    smpMax   = s.calMax;
    smpMin   = s.calMin;
    calMid   = 16'sh0000;
    capPP    = widen(s.capHi) - widen(s.capLo);
    trkPP    = widen(s.hiTrack) - widen(s.loTrack);
    newPP    = capPP;
    // threshold between captured peaks, with hysteresis
    thrMid   = widen(s.capLo) + (capPP >>> gts_pkg::FRAC_SHIFT);
    thrRise  = thrMid + gts_pkg::HYST;
    thrFall  = thrMid - gts_pkg::HYST;
    switched = 1'b0;

    next_s.procValid = sampleValid;
    if (sampleValid)
      next_s.diffSignal = satShift(corr, s.gainShift);

    case (s.mode)
      gts_pkg::MODE_CAL: begin
        if (sampleValid) begin
          if (s.calCount == 16'h0000) begin
            smpMax = sampleData;
            smpMin = sampleData;
          end else begin
            if (sampleData > s.calMax)
              smpMax = sampleData;
            if (sampleData < s.calMin)
              smpMin = sampleData;
          end
          next_s.calMax   = smpMax;
          next_s.calMin   = smpMin;
          next_s.calCount = s.calCount + 16'h0001;
          calMid = (widen(smpMax) + widen(smpMin)) >>> 1;
          // offset follows the running midpoint during calibration
          next_s.offset = nudge(s.offset, calMid - widen(s.offset));
          if (s.calCount == gts_pkg::CAL_SAMPLES - 16'h0001) begin
            next_s.offset    = satWord(calMid);
            next_s.gainShift = gainFor(widen(smpMax) - widen(smpMin));
            next_s.mode      = gts_pkg::MODE_RUN;
            next_s.hiTrack   = '0;
            next_s.loTrack   = '0;
            next_s.capHi     = gts_pkg::TARGET_HALF;
            next_s.capLo     = -gts_pkg::TARGET_HALF;
            next_s.gainCount = 4'h0;
          end
        end
      end
      gts_pkg::MODE_RUN: begin
        if (s.procValid) begin
          // two trackers, each clipped at the bound
          if (x > widen(s.hiTrack))
            next_s.hiTrack = clipBound(x);
          if (x < widen(s.loTrack))
            next_s.loTrack = clipBound(x);
          if (s.lockout) begin
            // output frozen until amplitude recovers
            if (trkPP >= gts_pkg::LOCK_MIN_PP) begin
              next_s.capHi   = s.hiTrack;
              next_s.capLo   = s.loTrack;
              next_s.lockout = 1'b0;
            end
          end else if (!s.out && x >= thrRise) begin
            // rising signal edge: valley peak just passed
            next_s.out    = 1'b1;
            next_s.capLo  = s.loTrack;
            newPP         = widen(s.capHi) - widen(s.loTrack);
            switched      = 1'b1;
          end else if (s.out && x <= thrFall) begin
            next_s.out    = 1'b0;
            next_s.capHi  = s.hiTrack;
            newPP         = widen(s.hiTrack) - widen(s.capLo);
            switched      = 1'b1;
          end
          if (switched) begin
            next_s.hiTrack = clipBound(x);
            next_s.loTrack = clipBound(x);
            next_s.lockout = newPP < gts_pkg::LOCK_MIN_PP;
            // midpoint of peaks steers the offset
            next_s.offset = nudge(s.offset,
              (widen(next_s.capHi) + widen(next_s.capLo)) >>> 1);
            // gain moves only after a persistent mismatch
            if ((newPP > gts_pkg::GAIN_HI_PP && s.gainShift != 3'h0) ||
                (newPP < gts_pkg::GAIN_LO_PP &&
                 newPP >= gts_pkg::LOCK_MIN_PP &&
                 s.gainShift != gts_pkg::MAX_SHIFT)) begin
              if (s.gainCount == gts_pkg::GAIN_PERSIST - 4'h1) begin
                next_s.gainCount = 4'h0;
                if (newPP > gts_pkg::GAIN_HI_PP)
                  next_s.gainShift = s.gainShift - 3'h1;
                else
                  next_s.gainShift = s.gainShift + 3'h1;
              end else begin
                next_s.gainCount = s.gainCount + 4'h1;
              end
            end else begin
              next_s.gainCount = 4'h0;
            end
          end
        end
      end
      default: begin
        next_s = resetState();
      end
    endcase

    next_s.pinLow = ~next_s.out;

    // undervoltage holds the power-on state
    if (!supplyOk)
      next_s = resetState();
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      s <= '{mode: gts_pkg::MODE_CAL, out: gts_pkg::POS_LEVEL,
             pinLow: ~gts_pkg::POS_LEVEL, default: '0};
    else
      s <= next_s;
  end

  // ==========================================================
  // outputs, three straight from flip-flops, calibrating decoded from mode
  always_comb begin
    outState     = s.out;
    outPinEnable = s.pinLow;
    calibrating  = (s.mode == gts_pkg::MODE_CAL);
    lockedOut    = s.lockout;
  end

endmodule // gts_switchpoint

`default_nettype wire

// [test/gts_switchpoint_chk.sv]
// checker for the gear-tooth switchpoint logic
// assumes it is bound to gts_switchpoint and sees its ports only
`default_nettype none

module gts_switchpoint_chk (
  // clock and reset
  input wire logic               clock,
  input wire logic               reset_n,
  // stream and supply
  input wire gts_pkg::gts_word_t sampleData,
  input wire logic               sampleValid,
  input wire logic               supplyOk,
  // outputs
  input wire logic               outState,
  input wire logic               outPinEnable,
  input wire logic               calibrating,
  input wire logic               lockedOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] calSeen;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // valid samples seen in calibration, saturating at 1024
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      calSeen <= 11'h000;
    else if (!supplyOk)
      calSeen <= 11'h000;
    else if (sampleValid && calibrating && calSeen != 11'h400)
      calSeen <= calSeen + 11'h001;
  end

  // ==========================================================
  // properties
  property p_pinInv;
    outPinEnable != outState;
  endproperty
  a_pinInv: assert property (p_pinInv)
    else $error("pin enable not inverse of output");
  property p_uvReset;
    !supplyOk |=> !outState && calibrating && !lockedOut;
  endproperty
  a_uvReset: assert property (p_uvReset)
    else $error("undervoltage did not restore power-on state");
  property p_calLow;
    calibrating |-> !outState;
  endproperty
  a_calLow: assert property (p_calLow)
    else $error("output moved during calibration");
  property p_calSpan;
    $fell(calibrating) |-> calSeen == 11'h400;
  endproperty
  a_calSpan: assert property (p_calSpan)
    else $error("calibration ended at wrong sample count");
  property p_freeze;
    lockedOut && $past(lockedOut) |-> $stable(outState);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("output moved during lockout");
  property p_cause;
    $changed(outState) && $past(supplyOk)
      |-> $past(sampleValid, 2) && $past(supplyOk, 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("output switched without a sample two edges before");
  property p_runOnly;
    $rose(outState) |-> !$past(calibrating);
  endproperty
  a_runOnly: assert property (p_runOnly)
    else $error("output rose too soon after calibration");
  property p_lockRun;
    lockedOut |-> !calibrating;
  endproperty
  a_lockRun: assert property (p_lockRun)
    else $error("lockout outside running mode");
endmodule // gts_switchpoint_chk

bind gts_switchpoint gts_switchpoint_chk u_chk (.clock(clock),
  .reset_n(reset_n), .sampleData(sampleData), .sampleValid(sampleValid),
  .supplyOk(supplyOk), .outState(outState), .outPinEnable(outPinEnable),
  .calibrating(calibrating), .lockedOut(lockedOut));

`default_nettype wire

// [test/gts_target_model.sv]
// target gear model: tooth or valley to differential samples
// assumes the bench drives toothNear, dir and amp off the falling edge
`default_nettype none

module gts_target_model (
  // target
  input  wire logic               toothNear,
  input  wire logic               dir,
  input  wire logic [11:0]        amp,
  // sample stream
  output var  gts_pkg::gts_word_t sampleData,
  output var  logic               sampleValid
);
  timeunit 1ns;
  timeprecision 1ns;
  // tooth gives a positive difference forward, reverse flips it
  always_comb begin
    sampleData  = (toothNear ^ dir) ? amp : -amp;
    sampleValid = 1'b1;
  end
endmodule // gts_target_model

`default_nettype wire

// [test/tb_gts_switchpoint.sv]
// testbench for the gear-tooth switchpoint logic
// assumes gts_switchpoint, its checker and the target model
`default_nettype none

module tb_gts_switchpoint;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] amp; logic dir; logic follow;} gts_row_t;
  gts_row_t rows [7] = '{'{12'h100, 1'b0, 1'b1}, '{12'h100, 1'b1, 1'b1},
    '{12'h0c0, 1'b0, 1'b1}, '{12'h020, 1'b0, 1'b0},
    '{12'h100, 1'b0, 1'b1}, '{12'h100, 1'b1, 1'b1},
    '{12'h500, 1'b0, 1'b1}};
  logic clock, reset_n, supplyOk, toothNear, dir, sampleValid;
  logic outState, outPinEnable, calibrating, lockedOut;
  logic [11:0] amp;
  gts_pkg::gts_word_t sampleData;
  int num_errors = 0;
  int tests_run = 0;

  // ==========================================================
  // clock, model and design
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  gts_target_model u_target (.toothNear(toothNear), .dir(dir), .amp(amp),
    .sampleData(sampleData), .sampleValid(sampleValid));
  gts_switchpoint DUT (.clock(clock), .reset_n(reset_n),
    .sampleData(sampleData), .sampleValid(sampleValid),
    .supplyOk(supplyOk), .outState(outState),
    .outPinEnable(outPinEnable), .calibrating(calibrating),
    .lockedOut(lockedOut));

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic half_wave(input int n);
    repeat (n) @(negedge clock);
    toothNear = ~toothNear;
  endtask
  task automatic final_report;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    reset_n = 1'b0;
    supplyOk = 1'b1;
    toothNear = 1'b0;
    dir = 1'b0;
    amp = 12'h100;
    repeat (4) @(negedge clock);
    chk("reset out", 1'b0, outState);
    reset_n = 1'b1;
    // calibration on a live target
    repeat (140) half_wave(8);
    chk("calibrating", 1'b0, calibrating);
    foreach (rows[r]) begin
      amp = rows[r].amp;
      dir = rows[r].dir;
      for (int h = 0; h < 10; h++) begin
        repeat (8) @(negedge clock);
        if (h > 4 && rows[r].follow)
          chk("out", toothNear ^ dir, outState);
        if (h > 4 && rows[r].follow)
          chk("pin", ~(toothNear ^ dir), outPinEnable);
        if (h > 4 && rows[r].follow)
          chk("nolock", 1'b0, lockedOut);
        if (h > 4 && !rows[r].follow)
          chk("lock", 1'b1, lockedOut);
        toothNear = ~toothNear;
      end
    end
    // undervoltage mid-run
    supplyOk = 1'b0;
    @(negedge clock);
    chk("uv out", 1'b0, outState);
    chk("uv cal", 1'b1, calibrating);
    chk("uv lock", 1'b0, lockedOut);
    supplyOk = 1'b1;
    repeat (20) half_wave(8);
    chk("recal out", 1'b0, outState);
    repeat (120) half_wave(8);
    chk("recal done", 1'b0, calibrating);
    toothNear = ~dir;
    repeat (8) @(negedge clock);
    chk("run out", 1'b1, outState);
    // reset in mid-run, then a clean release
    reset_n = 1'b0;
    #1;
    chk("async out", 1'b0, outState);
    chk("async pin", 1'b1, outPinEnable);
    chk("async cal", 1'b1, calibrating);
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    repeat (2) @(negedge clock);
    chk("release cal", 1'b1, calibrating);
    chk("release out", 1'b0, outState);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    final_report();
  end
endmodule // tb_gts_switchpoint

`default_nettype wire
